// ===== pkg/module_state_pkg.sv
// Purpose: shared constants and types for the module state data set builder
// Assumes: fifteen four-byte slots, CPU slot first, expansion slots in module order
// Notes:   state bits use 0 = fault, 1 = healthy; unused and reserved bits are driven to 1
package module_state_pkg;

    // data set geometry
    localparam int          NUM_EXP    = 14;
    localparam int          NUM_SLOTS  = 15;
    localparam int          SLOT_BYTES = 4;
    localparam int          SET_BYTES  = 60;
    localparam int          ADDR_W     = 6;
    localparam logic [5:0]  LAST_ADDR  = 6'h3B;
    localparam logic [5:0]  FIRST_ADDR = 6'h00;

    // stream buffer shape
    localparam int          FIFO_DEPTH = 8;
    localparam int          FIFO_WIDTH = 15;

    // fixed fill values
    localparam logic [7:0]  BYTE_ONES  = 8'hFF;
    localparam logic [31:0] REC_ONES   = 32'hFFFFFFFF;

    // byte 0 positions, safe and non-safe modules
    localparam int          B0_FAST    = 6;
    localparam int          B0_SUPPLY  = 5;
    localparam int          B0_CONFIG  = 4;
    localparam int          B0_EXT     = 2;
    localparam int          B0_INT     = 1;
    // byte 1 positions, safe and non-safe modules
    localparam int          B1_OUTDATA = 7;
    localparam int          B1_INDATA  = 6;
    // byte 0 positions, gateway modules
    localparam int          GW_OUTDATA = 6;
    localparam int          GW_INDATA  = 5;
    localparam int          GW_CONFIG  = 4;
    localparam int          GW_INT     = 1;

    // kind of module sitting in an expansion slot
    typedef enum logic [1:0] {KIND_SAFE, KIND_NONSAFE, KIND_GATEWAY, KIND_SPARE} slot_kind_t;

    // diagnostic results of one expansion slot, 1 = healthy
    typedef struct packed {
        logic       present;
        slot_kind_t kind;
        logic       fastOk;
        logic       supplyOk;
        logic       configOk;
        logic       extOk;
        logic       intOk;
        logic       outDataOk;
        logic       inDataOk;
        logic [3:0] twoChanOk;
        logic [7:0] pulseOk;
        logic [3:0] stuckHighOk;
        logic [3:0] stuckLowOk;
    } slot_diag_t;

endpackage

// ===== rtl/slot_record_encoder.sv
// Purpose: turns one slot's diagnostic results into its four state bytes
// Assumes: inputs already synchronised; purely combinational
// Notes:   rec[n] is state byte n; every bit not carrying a result stays at 1
`timescale 1ns/1ps
module slot_record_encoder (
    input  wire module_state_pkg::slot_diag_t diag,
    output logic [3:0][7:0]                  rec
);

    // build the record from the kind of module present
    always_comb begin
        rec = module_state_pkg::REC_ONES; // reserved, unused and absent bits all read 1
        if (diag.present) begin
            case (diag.kind)
                module_state_pkg::KIND_SAFE: begin
                    rec[0][module_state_pkg::B0_FAST]    = diag.fastOk;
                    rec[0][module_state_pkg::B0_SUPPLY]  = diag.supplyOk;
                    rec[0][module_state_pkg::B0_CONFIG]  = diag.configOk;
                    rec[0][module_state_pkg::B0_EXT]     = diag.extOk;
                    rec[0][module_state_pkg::B0_INT]     = diag.intOk;
                    rec[1][module_state_pkg::B1_OUTDATA] = diag.outDataOk;
                    rec[1][module_state_pkg::B1_INDATA]  = diag.inDataOk;
                    rec[1][3:0]                          = diag.twoChanOk;
                    rec[2]                               = diag.pulseOk;
                    // stuck-high at even bit, stuck-low just above
                    for (int k = 0; k < 4; k++) begin
                        rec[3][2*k]   = diag.stuckHighOk[k];
                        rec[3][2*k+1] = diag.stuckLowOk[k];
                    end
                end
                module_state_pkg::KIND_NONSAFE: begin
                    rec[0][module_state_pkg::B0_SUPPLY]  = diag.supplyOk;
                    rec[0][module_state_pkg::B0_CONFIG]  = diag.configOk;
                    rec[0][module_state_pkg::B0_EXT]     = diag.extOk;
                    rec[0][module_state_pkg::B0_INT]     = diag.intOk;
                    rec[1][module_state_pkg::B1_OUTDATA] = diag.outDataOk;
                    rec[1][module_state_pkg::B1_INDATA]  = diag.inDataOk;
                end
                module_state_pkg::KIND_GATEWAY: begin
                    rec[0][module_state_pkg::GW_OUTDATA] = diag.outDataOk;
                    rec[0][module_state_pkg::GW_INDATA]  = diag.inDataOk;
                    rec[0][module_state_pkg::GW_CONFIG]  = diag.configOk;
                    rec[0][module_state_pkg::GW_INT]     = diag.intOk;
                end
                default: begin
                    rec = module_state_pkg::REC_ONES; // spare code reports like an empty slot
                end
            endcase
        end
    end

endmodule

// ===== rtl/stream_fifo.sv
// Purpose: small synchronous FIFO between the frame builder and the network port
// Assumes: DEPTH is a power of two
// Notes:   output word comes straight from the storage array
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rstSyncN,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } fifo_state_t;

    fifo_state_t st_ff;
    fifo_state_t nxt_st;
    logic        doPush;
    logic        doPop;

    // honest full and empty from the fill count
    assign inReady  = (st_ff.cnt != (AW+1)'(DEPTH));
    assign outValid = (st_ff.cnt != '0);
    assign outData  = st_ff.mem[st_ff.rd];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    // pointer and count update
    always_comb begin
        nxt_st = st_ff;
        if (doPush) begin
            nxt_st.mem[st_ff.wr] = inData;
            nxt_st.wr            = AW'(st_ff.wr + 1'b1);
        end
        if (doPop) begin
            nxt_st.rd = AW'(st_ff.rd + 1'b1);
        end
        if (doPush && !doPop) begin
            nxt_st.cnt = (AW+1)'(st_ff.cnt + 1'b1);
        end else if (doPop && !doPush) begin
            nxt_st.cnt = (AW+1)'(st_ff.cnt - 1'b1);
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

// ===== rtl/module_state_status_bytes.sv
// Purpose: builds the 60-byte module state data set and streams it to the network side
// Assumes: diagnostic inputs arrive from other logic asynchronously and are resynchronised here
// Notes:   one snapshot per frame; frames repeat back to back, stalled only by netReady
//
// Behaviour
// - every state bit reads 0 for a fault and 1 for healthy operation
// - safe module byte 0: fast shut-off, supply, config, external, internal; bit 7 reserved
// - safe module byte 1: output data bit 7, input data bit 6, two-channel bits 3..0
// - safe module byte 2: test pulse result of input n at bit n-1
// - safe module byte 3: output k stuck-high at bit 2(k-1), stuck-low next
// - non-safe module: supply, config, external, internal in byte 0; data states in byte 1
// - non-safe modules carry meaning in bytes 0 and 1, gateway modules in byte 0 only, rest reserved
// - gateway byte 0: output data, input data, config, internal; others reserved
// - every reserved bit is a constant 1
// - unused history and executing bits read 1; reader ignores them
// - an empty slot reports all ones, reserved bits included
// - data set is 60 bytes: CPU slot first, then one slot per module
// - within a slot byte 3 goes first and byte 0 last
`timescale 1ns/1ps
module module_state_status_bytes (
    input  wire logic                                       ref_clk,
    input  wire logic                                       rst_n,
    input  wire logic [3:0][7:0]                            cpuStateBytes,
    input  wire logic [module_state_pkg::NUM_EXP-1:0]       slotPresent,
    input  wire logic [module_state_pkg::NUM_EXP-1:0][1:0]  slotKind,
    input  wire logic [module_state_pkg::NUM_EXP-1:0]       fastShutOk,
    input  wire logic [module_state_pkg::NUM_EXP-1:0]       supplyOk,
    input  wire logic [module_state_pkg::NUM_EXP-1:0]       configOk,
    input  wire logic [module_state_pkg::NUM_EXP-1:0]       extStateOk,
    input  wire logic [module_state_pkg::NUM_EXP-1:0]       intStateOk,
    input  wire logic [module_state_pkg::NUM_EXP-1:0]       outDataOk,
    input  wire logic [module_state_pkg::NUM_EXP-1:0]       inDataOk,
    input  wire logic [module_state_pkg::NUM_EXP-1:0][3:0]  twoChanOk,
    input  wire logic [module_state_pkg::NUM_EXP-1:0][7:0]  testPulseOk,
    input  wire logic [module_state_pkg::NUM_EXP-1:0][3:0]  stuckHighOk,
    input  wire logic [module_state_pkg::NUM_EXP-1:0][3:0]  stuckLowOk,
    output logic      [7:0]                                 netData,
    output logic      [5:0]                                 netAddr,
    output logic                                            netLast,
    output logic                                            netValid,
    input  wire logic                                       netReady,
    output logic                                            frameBusy
);

    // frame phases
    typedef enum logic {ST_SNAP, ST_SEND} phase_t;

    // whole module state
    typedef struct packed {
        module_state_pkg::slot_diag_t [module_state_pkg::NUM_EXP-1:0]   diagMeta;
        module_state_pkg::slot_diag_t [module_state_pkg::NUM_EXP-1:0]   diagSync;
        logic [3:0][7:0]                                                cpuMeta;
        logic [3:0][7:0]                                                cpuSync;
        phase_t                                                         phase;
        logic [module_state_pkg::SET_BYTES-1:0][7:0]                    snap;
        logic [5:0]                                                     addr;
    } core_state_t;

    core_state_t                                                 st_ff;
    core_state_t                                                 nxt_st;
    logic [1:0]                                                  rstPipe_ff;
    logic                                                        rstSyncN;
    module_state_pkg::slot_diag_t [module_state_pkg::NUM_EXP-1:0] diagIn;
    logic [module_state_pkg::NUM_EXP-1:0][3:0][7:0]              recs;
    logic [module_state_pkg::NUM_SLOTS-1:0][3:0][7:0]            allRecs;
    logic                                                        pushValid;
    logic                                                        pushReady;
    logic [module_state_pkg::FIFO_WIDTH-1:0]                     pushWord;
    logic [module_state_pkg::FIFO_WIDTH-1:0]                     popWord;
    logic                                                        pushLast;

    // byte at network address a: slot a/4, state byte 3 - a%4
    function automatic logic [7:0] set_byte(
        input logic [module_state_pkg::NUM_SLOTS-1:0][3:0][7:0] r,
        input int                                               a
    );
        set_byte = r[a / module_state_pkg::SLOT_BYTES][(module_state_pkg::SLOT_BYTES - 1)
                   - (a % module_state_pkg::SLOT_BYTES)];
    endfunction

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_ff <= 2'h0;
        end else begin
            rstPipe_ff <= {rstPipe_ff[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe_ff[1];

    // gather the loose per-slot ports into records
    always_comb begin
        for (int i = 0; i < module_state_pkg::NUM_EXP; i++) begin
            diagIn[i].present     = slotPresent[i];
            diagIn[i].kind        = module_state_pkg::slot_kind_t'(slotKind[i]);
            diagIn[i].fastOk      = fastShutOk[i];
            diagIn[i].supplyOk    = supplyOk[i];
            diagIn[i].configOk    = configOk[i];
            diagIn[i].extOk       = extStateOk[i];
            diagIn[i].intOk       = intStateOk[i];
            diagIn[i].outDataOk   = outDataOk[i];
            diagIn[i].inDataOk    = inDataOk[i];
            diagIn[i].twoChanOk   = twoChanOk[i];
            diagIn[i].pulseOk     = testPulseOk[i];
            diagIn[i].stuckHighOk = stuckHighOk[i];
            diagIn[i].stuckLowOk  = stuckLowOk[i];
        end
    end

    // one encoder per expansion slot, fed from the second sync stage
    for (genvar g = 0; g < module_state_pkg::NUM_EXP; g++) begin : gSlot
        slot_record_encoder uEnc (
            .diag (st_ff.diagSync[g]),
            .rec  (recs[g])
        );

        // empty slot reads all ones
        absentSlot_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
            !st_ff.diagSync[g].present |-> recs[g] == module_state_pkg::REC_ONES)
            else $error("empty slot record not all ones");

        // safe module stuck-at byte interleaves high and low per output
        stuckLayout_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
            st_ff.diagSync[g].present && st_ff.diagSync[g].kind == module_state_pkg::KIND_SAFE
            |-> recs[g][3] == {st_ff.diagSync[g].stuckLowOk[3], st_ff.diagSync[g].stuckHighOk[3],
                               st_ff.diagSync[g].stuckLowOk[2], st_ff.diagSync[g].stuckHighOk[2],
                               st_ff.diagSync[g].stuckLowOk[1], st_ff.diagSync[g].stuckHighOk[1],
                               st_ff.diagSync[g].stuckLowOk[0], st_ff.diagSync[g].stuckHighOk[0]})
            else $error("safe stuck-at byte misplaced");

        // safe module bytes 1 and 2 with their reserved bits
        safeLayout_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
            st_ff.diagSync[g].present && st_ff.diagSync[g].kind == module_state_pkg::KIND_SAFE
            |-> recs[g][1] == {st_ff.diagSync[g].outDataOk, st_ff.diagSync[g].inDataOk, 2'h3,
                               st_ff.diagSync[g].twoChanOk}
                && recs[g][2] == st_ff.diagSync[g].pulseOk && recs[g][0][7] && recs[g][0][3])
            else $error("safe byte 1 or 2 wrong");

        // gateway record: only byte 0 carries results
        gatewayLayout_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
            st_ff.diagSync[g].present && st_ff.diagSync[g].kind == module_state_pkg::KIND_GATEWAY
            |-> recs[g][0] == {1'b1, st_ff.diagSync[g].outDataOk, st_ff.diagSync[g].inDataOk,
                               st_ff.diagSync[g].configOk, 2'h3, st_ff.diagSync[g].intOk, 1'b1}
                && recs[g][3:1] == 24'hFFFFFF)
            else $error("gateway record wrong");

        // non-safe record: bytes 2 and 3 reserved, byte 1 low bits reserved
        nonsafeLayout_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
            st_ff.diagSync[g].present && st_ff.diagSync[g].kind == module_state_pkg::KIND_NONSAFE
            |-> recs[g][3:2] == 16'hFFFF && recs[g][1][5:0] == 6'h3F
                && recs[g][0][7:6] == 2'h3 && recs[g][0][3] && recs[g][0][0]
                && recs[g][0][1] == st_ff.diagSync[g].intOk)
            else $error("non-safe record wrong");
    end

    // CPU slot first, expansion slots after it in module order
    assign allRecs = {recs, st_ff.cpuSync};

    // frame builder: snapshot, then walk all sixty addresses
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.diagMeta = diagIn;
        nxt_st.diagSync = st_ff.diagMeta;
        nxt_st.cpuMeta  = cpuStateBytes;
        nxt_st.cpuSync  = st_ff.cpuMeta;
        case (st_ff.phase)
            ST_SNAP: begin
                // fresh copy of every slot each frame
                for (int a = 0; a < module_state_pkg::SET_BYTES; a++) begin
                    nxt_st.snap[a] = set_byte(allRecs, a);
                end
                nxt_st.addr  = module_state_pkg::FIRST_ADDR;
                nxt_st.phase = ST_SEND;
            end
            ST_SEND: begin
                // advance only when the buffer took the byte
                if (pushReady) begin
                    if (st_ff.addr == module_state_pkg::LAST_ADDR) begin
                        nxt_st.phase = ST_SNAP;
                    end else begin
                        nxt_st.addr = 6'(st_ff.addr + 6'h01);
                    end
                end
            end
            default: begin
                nxt_st.phase = ST_SNAP;
            end
        endcase
    end

    // state register; snapshot starts all ones but is retaken before any push, so the first frame's CPU slot reads 0
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            st_ff       <= '0;
            st_ff.snap  <= '1;
            st_ff.phase <= ST_SNAP;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // push side of the buffer
    assign pushValid = (st_ff.phase == ST_SEND);
    assign pushLast  = (st_ff.addr == module_state_pkg::LAST_ADDR);
    assign pushWord  = {pushLast, st_ff.addr, st_ff.snap[st_ff.addr]};

    stream_fifo #(
        .WIDTH (module_state_pkg::FIFO_WIDTH),
        .DEPTH (module_state_pkg::FIFO_DEPTH)
    ) uFifo (
        .clk      (ref_clk),
        .rstSyncN (rstSyncN),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (pushWord),
        .outValid (netValid),
        .outReady (netReady),
        .outData  (popWord)
    );

    // network side fields, taken from the buffer storage
    assign netData   = popWord[7:0];
    assign netAddr   = popWord[13:8];
    assign netLast   = popWord[14];
    assign frameBusy = (st_ff.phase == ST_SEND);

    // frame ends on address 59, then one snapshot cycle, then address 0
    frameWrap_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        pushValid && pushReady && st_ff.addr == module_state_pkg::LAST_ADDR
        |=> st_ff.phase == ST_SNAP ##1 (st_ff.phase == ST_SEND && st_ff.addr == 6'h00))
        else $error("frame did not wrap after byte 59");

    // addresses step by one per accepted byte, hold while stalled
    addrStep_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        pushValid && st_ff.addr != module_state_pkg::LAST_ADDR
        |=> st_ff.addr == ($past(pushReady) ? 6'($past(st_ff.addr) + 6'h01) : $past(st_ff.addr)))
        else $error("address step wrong");

    // CPU slot sits at addresses 0..3 in reverse byte order
    cpuFirst_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        st_ff.phase == ST_SNAP
        |=> st_ff.snap[3:0] == {$past(st_ff.cpuSync[0]), $past(st_ff.cpuSync[1]),
                                $past(st_ff.cpuSync[2]), $past(st_ff.cpuSync[3])})
        else $error("CPU slot misplaced");

    // byte 0 of the second expansion module lands at address 11, byte 3 at 8, last module byte 0 at 59
    slotOrder_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        st_ff.phase == ST_SNAP
        |=> st_ff.snap[11] == $past(recs[1][0]) && st_ff.snap[8] == $past(recs[1][3])
            && st_ff.snap[59] == $past(recs[module_state_pkg::NUM_EXP-1][0]))
        else $error("reverse byte order broken");

    // a fault present at snapshot shows as 0 in that frame's data
    faultRefresh_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        st_ff.phase == ST_SNAP && st_ff.diagSync[0].present && !st_ff.diagSync[0].intOk
        && st_ff.diagSync[0].kind != module_state_pkg::KIND_SPARE
        |=> !st_ff.snap[7][module_state_pkg::B0_INT])
        else $error("fault not carried into frame");

    // byte pushed matches the snapshot at its address, address stays inside the set
    pushData_a: assert property (@(posedge ref_clk) disable iff (!rstSyncN)
        pushValid |-> pushWord[13:8] <= module_state_pkg::LAST_ADDR && pushWord[7:0] == st_ff.snap[st_ff.addr]
            && pushWord[14] == (pushWord[13:8] == module_state_pkg::LAST_ADDR))
        else $error("pushed byte differs from snapshot");

    // main scenarios
    frameDone_c: cover property (@(posedge ref_clk) disable iff (!rstSyncN)
        netValid && netReady && netLast);
    stall_c: cover property (@(posedge ref_clk) disable iff (!rstSyncN)
        pushValid && !pushReady);
    safeFault_c: cover property (@(posedge ref_clk) disable iff (!rstSyncN)
        st_ff.phase == ST_SNAP && st_ff.diagSync[1].present && recs[1][3] != 8'hFF);

endmodule

// ===== verif/net_sink_model.sv
// Purpose: network master model reading the module state data set
// Assumes: one byte is taken at each edge with netValid and netReady high
// Notes:   slow mode stalls about three cycles in four so the stream buffer fills
`timescale 1ns/1ps
module net_sink_model (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             slow,
    input  wire logic             netValid,
    input  wire logic [7:0]       netData,
    input  wire logic [5:0]       netAddr,
    input  wire logic             netLast,
    output logic                  netReady,
    output logic      [59:0][7:0] got,
    output int                    frames,
    output logic                  lastBad
);
    // store each byte at its address, count frames at the closing byte
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            netReady <= 1'b0;
            got      <= '0;
            frames   <= 0;
            lastBad  <= 1'b0;
        end else begin
            netReady <= slow ? ($urandom_range(3, 0) == 0) : 1'b1;
            if (netValid && netReady) begin
                got[netAddr] <= netData;
                if (netLast)
                    frames <= frames + 1;
                if (netLast != (netAddr == 6'h3B))
                    lastBad <= 1'b1;
            end
        end
    end
endmodule

// ===== verif/module_state_status_bytes_tb.sv
// Purpose: self-checking bench for the module state data set builder
// Assumes: three frames after an input change always carry the new snapshot
// Notes:   unused history and executing bits of expansion byte 0 are masked out
`timescale 1ns/1ps
module module_state_status_bytes_tb;
    localparam int NE = module_state_pkg::NUM_EXP;
    logic               ref_clk, rst_n, slow, netValid, netReady, netLast, frameBusy, lastBad;
    logic [3:0][7:0]    cpuStateBytes;
    logic [NE-1:0]      slotPresent, fastShutOk, supplyOk, configOk, extStateOk, intStateOk, outDataOk, inDataOk;
    logic [NE-1:0][1:0] slotKind;
    logic [NE-1:0][3:0] twoChanOk, stuckHighOk, stuckLowOk;
    logic [NE-1:0][7:0] testPulseOk;
    logic [7:0]         netData, m8;
    logic [5:0]         netAddr;
    logic [59:0][7:0]   got;
    logic [31:0]        v, m;
    int                 frames, err_count, total_checks;
    int                 idleSeen = 0;
    logic               busyBad = 1'b0, busyLow = 1'b0;
    module_state_status_bytes u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cpuStateBytes(cpuStateBytes),
        .slotPresent(slotPresent), .slotKind(slotKind), .fastShutOk(fastShutOk), .supplyOk(supplyOk),
        .configOk(configOk), .extStateOk(extStateOk), .intStateOk(intStateOk), .outDataOk(outDataOk),
        .inDataOk(inDataOk), .twoChanOk(twoChanOk), .testPulseOk(testPulseOk), .stuckHighOk(stuckHighOk),
        .stuckLowOk(stuckLowOk), .netData(netData), .netAddr(netAddr), .netLast(netLast),
        .netValid(netValid), .netReady(netReady), .frameBusy(frameBusy));
    net_sink_model u_sink (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .netValid(netValid),
        .netData(netData), .netAddr(netAddr), .netLast(netLast), .netReady(netReady), .got(got),
        .frames(frames), .lastBad(lastBad));
    // free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // builder idles exactly one cycle per frame once frames flow
    always @(posedge ref_clk) begin
        busyBad  <= busyBad | (frames > 0 && busyLow && !frameBusy);
        busyLow  <= !frameBusy;
        idleSeen <= idleSeen + int'(frames > 0 && !frameBusy);
    end
    // expected byte at a network address
    function automatic logic [7:0] exp_byte(int a);
        int              i;
        logic [3:0][7:0] r;
        i = a / 4 - 1;
        r = '1;
        if (i < 0)
            return cpuStateBytes[3 - a % 4];
        if (slotPresent[i] && slotKind[i] == 2'h0) begin
            r[0] = {1'b1, fastShutOk[i], supplyOk[i], configOk[i], 1'b1, extStateOk[i], intStateOk[i], 1'b1};
            r[1] = {outDataOk[i], inDataOk[i], 2'h3, twoChanOk[i]};
            r[2] = testPulseOk[i];
            for (int k = 0; k < 4; k++)
                r[3][2*k +: 2] = {stuckLowOk[i][k], stuckHighOk[i][k]};
        end else if (slotPresent[i] && slotKind[i] == 2'h1) begin
            r[0] = {2'h3, supplyOk[i], configOk[i], 1'b1, extStateOk[i], intStateOk[i], 1'b1};
            r[1] = {outDataOk[i], inDataOk[i], 6'h3F};
        end else if (slotPresent[i] && slotKind[i] == 2'h2)
            r[0] = {1'b1, outDataOk[i], inDataOk[i], configOk[i], 2'h3, intStateOk[i], 1'b1};
        return r[3 - a % 4];
    endfunction
    // compare and count
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // bounded wait for n more complete frames
    task automatic wait_frames(int n);
        int f0;
        f0 = frames;
        for (int k = 0; k < 3000 && frames < f0 + n; k++)
            @(posedge ref_clk);
        if (frames < f0 + n) begin
            err_count++;
            $display("[FAIL] frame wait expected %0d seen %0d", f0 + n, frames);
            wrap_up();
        end
    endtask
    // main sequence: empty rack, all faults, then random racks
    initial begin
        {rst_n, slow, cpuStateBytes, slotPresent, slotKind, fastShutOk, supplyOk, configOk} = '0;
        {extStateOk, intStateOk, outDataOk, inDataOk, twoChanOk, testPulseOk, stuckHighOk, stuckLowOk} = '0;
        {err_count, total_checks} = '0;
        void'($urandom(32'h7F4B));
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int t = 0; t < 8; t++) begin
            @(posedge ref_clk);
            m = (t == 1) ? 32'h0 : 32'hFFFFFFFF;
            slow <= t[0];
            cpuStateBytes <= $urandom;
            for (int i = 0; i < NE; i++) begin
                v = $urandom & m;
                {slotKind[i], stuckLowOk[i], stuckHighOk[i], testPulseOk[i], twoChanOk[i]} <= v[28:7];
                {inDataOk[i], outDataOk[i], intStateOk[i], extStateOk[i]} <= v[6:3];
                {configOk[i], supplyOk[i], fastShutOk[i]} <= v[2:0];
                slotPresent[i] <= (t != 0);
            end
            wait_frames(3);
            for (int a = 0; a < 60; a++) begin
                m8 = (a > 3 && a % 4 == 3) ? 8'hF6 : 8'hFF;
                check($sformatf("addr %0d", a), got[a] & m8, exp_byte(a) & m8);
            end
            check("last flag", {7'h0, lastBad}, 8'h00);
            check("busy idle", {6'h0, busyBad, idleSeen == 0}, 8'h00);
            $display("test %0d done", t);
        end
        wrap_up();
    end
endmodule
